// ===== bus_matching_fifo.sv
`timescale 1ns/1ps
module bus_matching_fifo #(
	parameter int DEPTH  = 16,
	parameter int ADDR_W = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        nrst,
	// Device pins
	input  wire fifo_cfg_pkg::pins_t         pinsIn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Read port and flags
	output logic [fifo_cfg_pkg::DATA_W-1:0] dataOut,
	output logic                             dataOutEn,
	output logic                             emptyOrOutputValidFlagN,
	output logic                             readClockEcho,
	output logic                             powerDown
);
	localparam int CNT_W = ADDR_W + 1;
	localparam int DW    = fifo_cfg_pkg::DATA_W;

	typedef struct packed {
		fifo_cfg_pkg::cfg_t            cfg;
		logic [ADDR_W-1:0]             wrPtr;
		logic [ADDR_W-1:0]             rdPtr;
		logic [CNT_W-1:0]              count;
		logic [DW-1:0]                 wrAcc;
		logic [1:0]                    wrPiece;
		logic [DW-1:0]                 rdWord;
		logic [1:0]                    rdPiece;
		logic                          outValid;
		logic [DW-1:0]                 dataOut;
		logic                          dataOe;
		logic                          rcsAct;
		logic                          flagN;
		logic                          echo;
		logic                          powerDown;
		logic [fifo_cfg_pkg::OFFSET_W-1:0] offset;
		logic                          holdWrites;
		logic                          wrStrobePrev;
		logic                          rdStrobePrev;
		logic [31:0]                   prdata;
		logic                          pready;
		logic                          pslverr;
	} st_t;

	st_t                    stQ;
	st_t                    stD;
	fifo_cfg_pkg::pins_t    pinS;
	logic [$bits(fifo_cfg_pkg::pins_t)-1:0] pinsRaw;
	logic [DW-1:0]          mem [DEPTH];
	logic [DW-1:0]          memQ;
	logic                   memWe;
	logic [DW-1:0]          memWdata;
	logic                   mrsActive;
	logic                   prsActive;
	logic                   wrEdge;
	logic                   rdEdge;
	logic                   wrOp;
	logic                   rdOp;
	logic                   ldWrite;
	logic                   dataWrite;
	logic                   dataRead;
	logic                   activity;
	logic                   fullNow;
	logic [DW-1:0]          din;
	logic [DW-1:0]          accNext;
	logic [1:0]             lastIn;
	logic [1:0]             lastOut;
	logic [DW-1:0]          src;
	logic [DW-1:0]          piece;
	logic [DW-1:0]          rest;
	logic                   push;
	logic                   pop;
	logic                   advance;
	logic [31:0]            statusWord;
	fifo_cfg_pkg::cfg_t     cfgNew;

	pin_sync #(
		.WIDTH($bits(fifo_cfg_pkg::pins_t))
	) uPinSync (
		.clk (clk),
		.nrst(nrst),
		.d   (pinsIn),
		.q   (pinsRaw)
	);

	assign pinS = fifo_cfg_pkg::pins_t'(pinsRaw);
	assign din  = pinS.writeDataBus;
	assign memQ = mem[stQ.rdPtr];

	function automatic logic [ADDR_W-1:0] nextPtr(logic [ADDR_W-1:0] p);
		return (p == ADDR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// Operation qualifiers
	assign mrsActive = ~pinS.masterResetN;
	assign prsActive = ~pinS.partialResetN;
	assign wrEdge    = pinS.writeStrobe & ~stQ.wrStrobePrev;
	assign rdEdge    = pinS.readStrobe & ~stQ.rdStrobePrev;
	assign wrOp      = ~mrsActive & ~prsActive & ~pinS.writeEnableN &
		(stQ.cfg.writeSync | wrEdge);
	assign rdOp      = ~mrsActive & ~prsActive & ~pinS.readEnableN &
		(stQ.cfg.readSync | rdEdge);
	assign ldWrite   = wrOp & ~pinS.loadN;
	assign dataWrite = wrOp & pinS.loadN & ~stQ.holdWrites;
	assign dataRead  = rdOp & pinS.loadN;
	assign activity  = wrOp | rdOp | mrsActive | prsActive | psel;
	assign fullNow   = (stQ.count == CNT_W'(DEPTH));

	// Width table decode
	always_comb begin
		cfgNew.bigEndian   = ~pinS.endianSelect;
		cfgNew.interParity = pinS.parityPlacementSelect;
		cfgNew.readSync    = pinS.readPortAsyncSelect;
		cfgNew.writeSync   = pinS.writePortAsyncSelect;
		// Fall-through is not usable with a strobed read port
		cfgNew.fallThrough = pinS.fallThroughMode &
			pinS.readPortAsyncSelect;
		if (!pinS.busMatchSelect) begin
			cfgNew.inWidth  = fifo_cfg_pkg::WIDTH_X72;
			cfgNew.outWidth = fifo_cfg_pkg::WIDTH_X72;
		end else if (!pinS.inputWidthSelect) begin
			cfgNew.inWidth  = fifo_cfg_pkg::WIDTH_X72;
			cfgNew.outWidth = pinS.outputWidthSelect ?
				fifo_cfg_pkg::WIDTH_X18 : fifo_cfg_pkg::WIDTH_X36;
		end else begin
			cfgNew.outWidth = fifo_cfg_pkg::WIDTH_X72;
			cfgNew.inWidth  = pinS.outputWidthSelect ?
				fifo_cfg_pkg::WIDTH_X18 : fifo_cfg_pkg::WIDTH_X36;
		end
	end

	// Write assembly: narrow pieces build a long word in endian order
	always_comb begin
		unique case (stQ.cfg.inWidth)
			fifo_cfg_pkg::WIDTH_X36: begin
				lastIn  = 2'h1;
				accNext = stQ.cfg.bigEndian ?
					{stQ.wrAcc[35:0], din[35:0]} :
					{din[35:0], stQ.wrAcc[71:36]};
			end
			fifo_cfg_pkg::WIDTH_X18: begin
				lastIn  = 2'h3;
				accNext = stQ.cfg.bigEndian ?
					{stQ.wrAcc[53:0], din[17:0]} :
					{din[17:0], stQ.wrAcc[71:18]};
			end
			default: begin
				lastIn  = 2'h0;
				accNext = din;
			end
		endcase
	end

	// Read split: the next piece comes from the held word or from memory
	always_comb begin
		src = (stQ.rdPiece != 2'h0) ? stQ.rdWord : memQ;
		unique case (stQ.cfg.outWidth)
			fifo_cfg_pkg::WIDTH_X36: begin
				lastOut = 2'h1;
				if (stQ.cfg.bigEndian) begin
					piece = {36'h0, src[71:36]};
					rest  = {src[35:0], 36'h0};
				end else begin
					piece = {36'h0, src[35:0]};
					rest  = {36'h0, src[71:36]};
				end
			end
			fifo_cfg_pkg::WIDTH_X18: begin
				lastOut = 2'h3;
				if (stQ.cfg.bigEndian) begin
					piece = {54'h0, src[71:54]};
					rest  = {src[53:0], 18'h0};
				end else begin
					piece = {54'h0, src[17:0]};
					rest  = {18'h0, src[71:18]};
				end
			end
			default: begin
				lastOut = 2'h0;
				piece   = src;
				rest    = '0;
			end
		endcase
	end

	always_comb begin
		statusWord = '0;
		statusWord[fifo_cfg_pkg::STAT_CFG_LSB +: $bits(fifo_cfg_pkg::cfg_t)] =
			stQ.cfg;
		statusWord[fifo_cfg_pkg::STAT_PWR_BIT] = stQ.powerDown;
		statusWord[fifo_cfg_pkg::STAT_EMP_BIT] = (stQ.count == '0);
		statusWord[fifo_cfg_pkg::STAT_FUL_BIT] = fullNow;
		statusWord[fifo_cfg_pkg::STAT_CNT_LSB +: CNT_W] = stQ.count;
	end

	always_comb begin
		stD      = stQ;
		memWe    = 1'b0;
		memWdata = accNext;
		push     = 1'b0;
		pop      = 1'b0;
		stD.wrStrobePrev = pinS.writeStrobe;
		stD.rdStrobePrev = pinS.readStrobe;
		// Write port
		if (dataWrite) begin
			stD.wrAcc = accNext;
			if (stQ.wrPiece == lastIn) begin
				stD.wrPiece = 2'h0;
				push        = ~fullNow;
			end else begin
				stD.wrPiece = stQ.wrPiece + 2'h1;
			end
		end
		memWe = push;
		if (ldWrite) begin
			stD.offset = stQ.cfg.interParity ?
				{din[34:27], din[25:18], din[16:9], din[7:0]} :
				din[31:0];
		end
		// Read port; fall-through refills an empty output on its own
		advance = dataRead | (stQ.cfg.fallThrough & ~stQ.outValid);
		if (advance) begin
			if (stQ.rdPiece != 2'h0) begin
				stD.dataOut  = piece;
				stD.rdWord   = rest;
				stD.rdPiece  = stQ.rdPiece - 2'h1;
				stD.outValid = 1'b1;
			end else if (stQ.count != '0) begin
				pop          = 1'b1;
				stD.dataOut  = piece;
				stD.rdWord   = rest;
				stD.rdPiece  = lastOut;
				stD.outValid = 1'b1;
			end else begin
				stD.outValid = 1'b0;
			end
		end
		if (pop) begin
			stD.rdPtr = nextPtr(stQ.rdPtr);
		end
		if (push) begin
			stD.wrPtr = nextPtr(stQ.wrPtr);
		end
		stD.count = stQ.count + CNT_W'(push) - CNT_W'(pop);
		// Resets: master reset reloads settings, partial keeps them
		if (mrsActive) begin
			stD.cfg     = cfgNew;
			stD.offset  = '0;
			stD.dataOut = '0;
		end
		if (mrsActive | prsActive) begin
			stD.wrPtr    = '0;
			stD.rdPtr    = '0;
			stD.count    = '0;
			stD.wrPiece  = 2'h0;
			stD.rdPiece  = 2'h0;
			stD.outValid = 1'b0;
			memWe        = 1'b0;
		end
		stD.rcsAct = ~pinS.readSelectSyncN;
		stD.dataOe = ~pinS.outputEnableN & stQ.rcsAct;
		stD.flagN  = stD.cfg.fallThrough ? ~stD.outValid :
			(stD.count != '0);
		stD.echo      = stQ.cfg.readSync & ~stQ.echo;
		stD.powerDown = ~activity;
		// APB: data prepared in setup, answered in the first access cycle
		stD.pready  = 1'b0;
		stD.pslverr = 1'b0;
		if (psel & ~penable) begin
			stD.pready = 1'b1;
			stD.prdata = '0;
			case (paddr)
				fifo_cfg_pkg::ADDR_CTRL:
					stD.prdata[fifo_cfg_pkg::CTRL_HOLD_BIT] = stQ.holdWrites;
				fifo_cfg_pkg::ADDR_STATUS: stD.prdata = statusWord;
				fifo_cfg_pkg::ADDR_OFFSET: stD.prdata = stQ.offset;
				default: stD.pslverr = 1'b1;
			endcase
		end
		if (psel & penable & stQ.pready & pwrite &
			(paddr == fifo_cfg_pkg::ADDR_CTRL)) begin
			stD.holdWrites = pwdata[fifo_cfg_pkg::CTRL_HOLD_BIT];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stQ            <= '0;
			stQ.cfg        <= fifo_cfg_pkg::CFG_RESET;
			stQ.holdWrites <= fifo_cfg_pkg::CTRL_HOLD_RESET;
		end else begin
			stQ <= stD;
		end
	end

	always_ff @(posedge clk) begin
		if (memWe) begin
			mem[stQ.wrPtr] <= memWdata;
		end
	end

	assign prdata                  = stQ.prdata;
	assign pready                  = stQ.pready;
	assign pslverr                 = stQ.pslverr;
	assign dataOut                 = stQ.dataOut;
	assign dataOutEn               = stQ.dataOe;
	assign emptyOrOutputValidFlagN = stQ.flagN;
	assign readClockEcho           = stQ.echo;
	assign powerDown               = stQ.powerDown;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	AST_CFG_HOLD: assert property (
		!mrsActive |=> $stable(stQ.cfg))
		else $error("settings changed outside master reset");
	AST_X72: assert property (
		mrsActive && !pinS.busMatchSelect |=>
		stQ.cfg.inWidth == fifo_cfg_pkg::WIDTH_X72 &&
		stQ.cfg.outWidth == fifo_cfg_pkg::WIDTH_X72)
		else $error("x72 mode not latched");
	AST_ENDIAN: assert property (
		mrsActive |=> stQ.cfg.bigEndian == !$past(pinS.endianSelect))
		else $error("endian select latched wrongly");
	AST_OE: assert property (
		dataOutEn |-> $past(!pinS.outputEnableN) &&
		$past(!pinS.readSelectSyncN, 2))
		else $error("outputs driven while disabled");
	AST_PARITY: assert property (
		ldWrite && stQ.cfg.interParity && !mrsActive |=>
		stQ.offset == {$past(din[34:27]), $past(din[25:18]),
		$past(din[16:9]), $past(din[7:0])})
		else $error("parity bits not stripped");
	AST_NOPARITY: assert property (
		ldWrite && !stQ.cfg.interParity && !mrsActive |=>
		stQ.offset == $past(din[31:0]))
		else $error("offset bits lost");
	AST_WAKE: assert property (
		activity |=> !powerDown)
		else $error("power down while active");
	AST_SLEEP: assert property (
		!activity |=> powerDown)
		else $error("no power down while idle");
	AST_FLAG: assert property (
		!stQ.cfg.fallThrough |-> emptyOrOutputValidFlagN == (stQ.count != '0))
		else $error("empty flag wrong");
	AST_ECHO: assert property (
		(!stQ.cfg.readSync && !mrsActive) [*2] |=> !readClockEcho)
		else $error("echo toggles in strobed read mode");
	AST_AWRITE: assert property (
		memWe && !stQ.cfg.writeSync |-> wrEdge && !pinS.writeEnableN)
		else $error("strobed write without strobe edge");
endmodule // bus_matching_fifo

// ===== fifo_cfg_pkg.sv
package fifo_cfg_pkg;
	// Data path widths
	localparam int DATA_W    = 72;
	localparam int HALF_W    = 36;
	localparam int QUART_W   = 18;
	localparam int OFFSET_W  = 32;

	// APB register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_OFFSET = 8'h08;

	// Control register fields and reset value
	localparam int         CTRL_HOLD_BIT = 0;
	localparam logic       CTRL_HOLD_RESET = 1'b0;

	// Status register fields
	localparam int STAT_CFG_LSB = 0;
	localparam int STAT_PWR_BIT = 12;
	localparam int STAT_EMP_BIT = 13;
	localparam int STAT_FUL_BIT = 14;
	localparam int STAT_CNT_LSB = 16;
	localparam int STAT_CNT_W   = 16;

	typedef enum logic [1:0] {
		WIDTH_X72,
		WIDTH_X36,
		WIDTH_X18
	} width_t;

	typedef struct packed {
		width_t inWidth;
		width_t outWidth;
		logic   bigEndian;
		logic   interParity;
		logic   readSync;
		logic   writeSync;
		logic   fallThrough;
	} cfg_t;

	localparam cfg_t CFG_RESET = '{WIDTH_X72, WIDTH_X72, 1'b1, 1'b0,
		1'b1, 1'b1, 1'b0};

	typedef struct packed {
		logic                busMatchSelect;
		logic                inputWidthSelect;
		logic                outputWidthSelect;
		logic                endianSelect;
		logic                parityPlacementSelect;
		logic                readPortAsyncSelect;
		logic                writePortAsyncSelect;
		logic                fallThroughMode;
		logic                masterResetN;
		logic                partialResetN;
		logic                writeEnableN;
		logic                readEnableN;
		logic                writeStrobe;
		logic                readStrobe;
		logic                loadN;
		logic                outputEnableN;
		logic                readSelectSyncN;
		logic [DATA_W-1:0]   writeDataBus;
	} pins_t;
endpackage

// ===== pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Levels from outside the clock domain
	input  wire logic [WIDTH-1:0] d,
	// Levels in the clock domain
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} state_t;

	state_t stQ;
	state_t stD;

	always_comb begin
		stD.meta = d;
		stD.sync = stQ.meta;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stQ <= '0;
		end else begin
			stQ <= stD;
		end
	end

	assign q = stQ.sync;
endmodule // pin_sync

// ===== fifo_far_side.sv
`timescale 1ns/1ps
module fifo_far_side (
	// Clock
	input  wire logic           clk,
	// Device pins
	output fifo_cfg_pkg::pins_t pins
);
	initial begin
		pins = '0;
		pins.masterResetN = 1'b1;
		pins.partialResetN = 1'b1;
		pins.writeEnableN = 1'b1;
		pins.readEnableN = 1'b1;
		pins.loadN = 1'b1;
	end

	// Settings turn over after release to show they are latched
	task automatic mreset(input logic [7:0] c);
		pins[88:81] <= {c[7:1], c[0] & c[2]};
		pins.masterResetN <= 1'b0;
		repeat (5) @(posedge clk);
		pins.masterResetN <= 1'b1;
		@(posedge clk);
		pins[88:81] <= ~c;
		repeat (8) @(posedge clk);
	endtask

	task automatic put(input logic [71:0] d, input logic strb,
		input logic ld);
		pins.writeEnableN <= 1'b0;
		pins.loadN <= ~ld;
		pins.writeDataBus <= d;
		@(posedge clk);
		if (strb) begin
			pins.writeStrobe <= 1'b1;
			repeat (3) @(posedge clk);
			pins.writeStrobe <= 1'b0;
			repeat (2) @(posedge clk);
		end
		pins.writeEnableN <= 1'b1;
		pins.loadN <= 1'b1;
		pins.writeDataBus <= ~d;
		@(posedge clk);
	endtask

	task automatic take(input logic strb);
		pins.readEnableN <= 1'b0;
		@(posedge clk);
		if (strb) begin
			pins.readStrobe <= 1'b1;
			repeat (3) @(posedge clk);
			pins.readStrobe <= 1'b0;
			repeat (2) @(posedge clk);
		end
		pins.readEnableN <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
endmodule // fifo_far_side

// ===== bus_matching_fifo_bench.sv
`timescale 1ns/1ps
module bus_matching_fifo_bench;
	logic                clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic                dataOutEn, flagN, readClockEcho, powerDown, sawWake;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata;
	logic [71:0]         dataOut, lastOut;
	logic [71:0]         expQ[$];
	fifo_cfg_pkg::pins_t pins;
	int                  failures, testsRun;

	fifo_far_side u_fifo_far_side (.clk(clk), .pins(pins));

	bus_matching_fifo u_bus_matching_fifo (
		.clk(clk), .nrst(nrst), .pinsIn(pins), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dataOut(dataOut), .dataOutEn(dataOutEn),
		.emptyOrOutputValidFlagN(flagN), .readClockEcho(readClockEcho),
		.powerDown(powerDown)
	);

	task automatic check(input logic [71:0] seen, input logic [71:0] exp);
		testsRun++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (failures == 0 && testsRun > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [71:0] rnd72();
		logic [95:0] r;
		r = {$urandom(), $urandom(), $urandom()};
		return r[71:0];
	endfunction

	function automatic logic [71:0] pmask(input int n);
		return (72'h1 << (72 / n)) - 72'h1;
	endfunction

	// Piece k of a word, in transfer order
	function automatic logic [71:0] piece(input logic [71:0] w, input int n,
		input int k, input logic big);
		int idx;
		idx = big ? n - 1 - k : k;
		return (w >> (idx * (72 / n))) & pmask(n);
	endfunction

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (dataOut !== lastOut && expQ.size() > 0)
			check(dataOut, expQ.pop_front());
		lastOut <= dataOut;
		if (powerDown === 1'b0)
			sawWake <= 1'b1;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		report_and_stop();
	end

	initial begin
		logic [7:0]  cfgs [5];
		logic [7:0]  cf;
		logic [71:0] w [2];
		logic [71:0] d;
		logic [31:0] rd;
		logic        err;
		logic        e0;
		logic        e1;
		int          inN;
		int          outN;
		cfgs = '{8'h06, 8'h86, 8'hb6, 8'hd4, 8'he2};
		void'($urandom(98));
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		lastOut = '0;
		sawWake = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		foreach (cfgs[c]) begin
			cf = cfgs[c];
			inN = (cf[7] & cf[6]) ? (cf[5] ? 4 : 2) : 1;
			outN = (cf[7] & ~cf[6]) ? (cf[5] ? 4 : 2) : 1;
			u_fifo_far_side.mreset(cf);
			check(72'(flagN), 72'(0));
			check(72'(powerDown), 72'(1));
			sawWake = 1'b0;
			for (int i = 0; i < 2; i++) begin
				w[i] = rnd72();
				for (int k = 0; k < inN; k++) begin
					d = (rnd72() & ~pmask(inN)) | piece(w[i], inN, k, ~cf[4]);
					u_fifo_far_side.put(d, ~cf[1], 1'b0);
				end
			end
			repeat (4) @(posedge clk);
			check(72'(flagN), 72'(1));
			check(72'(sawWake), 72'(1));
			e0 = readClockEcho;
			@(posedge clk);
			e1 = readClockEcho;
			check(72'({e0 ^ e1, e0 | e1}), 72'({2{cf[2]}}));
			for (int i = 0; i < 2; i++)
				for (int k = 0; k < outN; k++) begin
					expQ.push_back(piece(w[i], outN, k, ~cf[4]));
					u_fifo_far_side.take(~cf[2]);
				end
			repeat (4) @(posedge clk);
			check(72'(expQ.size()), 72'(0));
			if (c == 0) begin
				check(72'(dataOutEn), 72'(1));
				for (int i = 0; i < 3; i++) begin
					u_fifo_far_side.pins.outputEnableN <= (i == 0);
					u_fifo_far_side.pins.readSelectSyncN <= (i == 1);
					repeat (5) @(posedge clk);
					check(72'(dataOutEn), 72'(i == 2));
				end
			end
		end
		// Fall-through: first word shows up without a read
		u_fifo_far_side.mreset(8'h07);
		check(72'(flagN), 72'(1));
		w[0] = rnd72();
		expQ.push_back(w[0]);
		u_fifo_far_side.put(w[0], 1'b0, 1'b0);
		repeat (8) @(posedge clk);
		check(72'(flagN), 72'(0));
		check(72'(expQ.size()), 72'(0));
		for (int ip = 0; ip < 2; ip++) begin
			u_fifo_far_side.mreset({4'h0, ip[0], 3'b110});
			d = rnd72();
			u_fifo_far_side.put(d, 1'b0, 1'b1);
			repeat (4) @(posedge clk);
			apb(1'b0, fifo_cfg_pkg::ADDR_OFFSET, 32'h0, rd, err);
			w[0] = 72'(ip ? {d[34:27], d[25:18], d[16:9], d[7:0]} : d[31:0]);
			check(72'(rd), w[0]);
		end
		apb(1'b0, fifo_cfg_pkg::ADDR_CTRL, 32'h0, rd, err);
		check(72'(rd), 72'(fifo_cfg_pkg::CTRL_HOLD_RESET));
		apb(1'b1, fifo_cfg_pkg::ADDR_CTRL, 32'h1, rd, err);
		apb(1'b0, fifo_cfg_pkg::ADDR_CTRL, 32'h0, rd, err);
		check(72'(rd), 72'(1));
		apb(1'b1, fifo_cfg_pkg::ADDR_CTRL, 32'h0, rd, err);
		apb(1'b0, 8'h0c, 32'h0, rd, err);
		check(72'(err), 72'(1));
		report_and_stop();
	end
endmodule // bus_matching_fifo_bench
